/* File: rtl/fctl_pkg.sv */
// fctl_pkg: constants, field layouts and shared decoding of the fuse calibration/trim loader.
// assumes: every file of the block imports this package; no clock or reset of its own.
package fctl_pkg;

   // store and register widths
   localparam int FUSE_W     = 188;
   localparam int CAL_W      = 110;
   localparam int TRIM_W     = 20;
   localparam int CONST_W    = 11;
   localparam int NUM_GAIN   = 4;
   localparam int NUM_VOLT   = 6;
   localparam int CFG_W      = 17;
   localparam int CNT_W      = 8;
   localparam logic [CONST_W-1:0] CONST_DEFAULT = 11'h60C;   // decimal 1548

   // serial configuration port framing
   localparam int HDR_BITS = 6;
   localparam logic [3:0] MODE_REG_ACCESS = 4'h8;
   localparam int HDR_MODE_LSB = 2;
   localparam int HDR_RW_BIT   = 1;                            // 1 = read
   localparam int HDR_SEL_BIT  = 0;                            // 1 = trim, 0 = calibration

   // fuse read clock: least half period, rounded up
   localparam int CLK_KHZ       = 50000;
   localparam int FUSE_RATE_KHZ = 500;
   localparam int FUSE_HALF_CYC = (CLK_KHZ + 2 * FUSE_RATE_KHZ - 1) / (2 * FUSE_RATE_KHZ);

   // measurement filter scaling
   localparam int RES_W     = 16;
   localparam int PROD_W    = RES_W + CONST_W + 1;
   localparam int CAL_SHIFT = 10;
   localparam logic signed [RES_W-1:0] RES_MAX = 16'sh7FFF;
   localparam logic signed [RES_W-1:0] RES_MIN = 16'sh8001;

   typedef struct packed {
      logic [4:0] trim_csrc;        // 19..15
      logic [4:0] trim_offset;      // 14..10
      logic [4:0] trim_reflevel;    // 9..5
      logic [4:0] trim_reftc;       // 4..0
   } fctl_trim_t;

   typedef struct packed {
      logic [47:0] test_data;
      logic        lock_1;
      logic        lock_0;
      logic        prog_one;
      logic        prog_zero;
      logic        sacrificial;
   } fctl_test_t;

   typedef struct packed {
      logic [4:0]       fuse_spare_field;         // 187..183
      fctl_trim_t       fuse_trim_field;          // 182..163
      logic [CAL_W-1:0] fuse_calibration_field;   // 162..53
      fctl_test_t       fuse_test_field;          // 52..0
   } fctl_fuse_t;

   typedef struct packed {
      logic [2:0] voltage_cal_select;   // 16..14
      logic [3:0] path_upper;           // 13..10
      logic       shunt_path_select;    // 9
      logic       gain_select_high;     // 8
      logic       gain_select_low;      // 7
      logic [6:0] filter_bits;          // 6..0
   } fctl_cfg_t;

   typedef enum logic [2:0] {
      SER_IDLE = 3'b001,
      SER_HDR  = 3'b010,
      SER_DATA = 3'b100
   } fctl_ser_t;

   typedef enum logic [1:0] {
      RD_SHIFT = 2'b01,
      RD_DONE  = 2'b10
   } fctl_rd_t;

   // slice k of the calibration register, first current-gain constant at the top
   function automatic logic [CONST_W-1:0] fctl_slice(input logic [CAL_W-1:0] cal,
                                                     input int k);
      return cal[CAL_W-1-CONST_W*k -: CONST_W];
   endfunction

   // constant chosen for a channel configuration
   function automatic logic [CONST_W-1:0] fctl_pick(input logic [CAL_W-1:0] cal,
                                                    input fctl_cfg_t cfg);
      int k;
      k = 0;
      if (cfg.shunt_path_select) begin
         k = int'({cfg.gain_select_high, cfg.gain_select_low});
         return fctl_slice(cal, k);
      end
      if (int'(cfg.voltage_cal_select) < NUM_VOLT) begin
         k = NUM_GAIN + int'(cfg.voltage_cal_select);
         return fctl_slice(cal, k);
      end
      return CONST_DEFAULT;
   endfunction

endpackage

/* File: rtl/fctl_fuse_reader.sv */
// fctl_fuse_reader: reads the one-time fuse store serially after reset.
// assumes: the fuse cells present their next bit after each rising FUSE_CLK, msb (187) first.
`timescale 1ns/1ns
module fctl_fuse_reader (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              fuse_bit,
   output fctl_pkg::fctl_fuse_t   fuse_store,
   output logic                   fuse_clk,
   output logic                   fuse_rd_en,
   output logic                   done
);
   import fctl_pkg::*;

   logic [5:0]        half_cnt_ff;
   logic              fuse_clk_ff;
   logic              bit_s1_ff;
   logic              bit_s2_ff;
   logic [FUSE_W-1:0] store_ff;
   logic [CNT_W-1:0]  bits_ff;
   fctl_rd_t          state_ff;

   // pin crosses two flops before use
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_s1_ff <= 1'b0;
         bit_s2_ff <= 1'b0;
      end else begin
         bit_s1_ff <= fuse_bit;
         bit_s2_ff <= bit_s1_ff;
      end
   end

   // divider keeps the cell clock at or below the weak-drive limit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         half_cnt_ff <= 6'h00;
         fuse_clk_ff <= 1'b0;
      end else if (state_ff == RD_SHIFT) begin
         if (half_cnt_ff == 6'(FUSE_HALF_CYC - 1)) begin
            half_cnt_ff <= 6'h00;
            fuse_clk_ff <= ~fuse_clk_ff;
         end else begin
            half_cnt_ff <= half_cnt_ff + 6'h01;
         end
      end else begin
         half_cnt_ff <= 6'h00;
         fuse_clk_ff <= 1'b0;
      end
   end

   // sample on the falling cell clock, half a period after the cell moved
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         store_ff <= '0;
         bits_ff  <= '0;
         state_ff <= RD_SHIFT;
      end else begin
         unique case (state_ff)
            RD_SHIFT: begin
               if (fuse_clk_ff && half_cnt_ff == 6'(FUSE_HALF_CYC - 1)) begin
                  store_ff <= {store_ff[FUSE_W-2:0], bit_s2_ff};
                  bits_ff  <= bits_ff + 8'h01;
                  if (bits_ff == 8'(FUSE_W - 1)) begin
                     state_ff <= RD_DONE;
                  end
               end
            end
            RD_DONE: begin
               state_ff <= RD_DONE;
            end
         endcase
      end
   end

   assign fuse_store = fctl_fuse_t'(store_ff);
   assign fuse_clk   = fuse_clk_ff;
   assign fuse_rd_en = (state_ff == RD_SHIFT);
   assign done       = (state_ff == RD_DONE);

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_fuse_rate;
      $changed(fuse_clk_ff) && $past(fuse_rd_en) |-> $past(half_cnt_ff) == 6'(FUSE_HALF_CYC - 1);
   endproperty
   a_fuse_rate: assert property (p_fuse_rate) else $error("fuse clock toggled early");

endmodule // fctl_fuse_reader

/* File: rtl/fctl_top.sv */
// fctl_top: calibration and trim registers, fuse copy, serial access and constant selection.
// assumes: SCLK, SEN and SDAT_I are asynchronous pins; channel configs and raw results
// come from logic on CLOCK.
//
// Operation
// - fuse store is 188 bits: spare 187-183, trim 182-163, cal 162-53, test 52-0
// - five test-field bits: sacrificial, programmed zero, programmed one, two lock bits
// - five spare fuse bits are reserved and drive nothing
// - fuse trim field holds four 5-bit trims, each defaulting to zero
// - fuse calibration field holds ten 11-bit constants defaulting to 1548
// - fuse cells are clocked no faster than 500 kHz
// - shunt path set: gain bits pick one of four current-gain constants
// - shunt path clear: voltage select 0-5 picks voltage constant, 6-7 pick 1548
// - each conversion result after the fuse copy is corrected with the selected constant
// - power-up copies the fuse calibration field into the calibration register
// - calibration register read/written in access mode 8; writes replace fuse values
// - first current-gain constant at 109-99, last voltage constant at 10-0, default 1548
// - power-up copies the fuse trim field into the trim register
// - trim register read/written in access mode 8; writes replace fuse values
// - trim layout: current source, offset, level, temp-coefficient; all reset to zero
// - voltage select at 16-14, shunt path at 9, gain bits at 8 and 7
// - shunt path set closes the current-sense input switch
`timescale 1ns/1ns
module fctl_top (
   input  wire logic                                CLOCK,
   input  wire logic                                RST_B,
   output logic                                     FUSE_CLK,
   output logic                                     FUSE_RD_EN,
   input  wire logic                                FUSE_BIT,
   input  wire logic                                SCLK,
   input  wire logic                                SEN,
   input  wire logic                                SDAT_I,
   output logic                                     SDAT_O,
   output logic                                     SDAT_OE,
   input  wire fctl_pkg::fctl_cfg_t                 CHAN_A_CFG,
   input  wire fctl_pkg::fctl_cfg_t                 CHAN_B_CFG,
   input  wire logic                                CHAN_B_ACTIVE,
   input  wire logic                                RAW_VALID,
   input  wire logic signed [fctl_pkg::RES_W-1:0]   RAW_RESULT,
   output logic                                     CORR_VALID,
   output logic signed [fctl_pkg::RES_W-1:0]        CORR_RESULT,
   output logic                                     CORR_OVF,
   output logic [fctl_pkg::CONST_W-1:0]             CAL_CONST,
   output logic                                     SHUNT_SWITCH_CLOSE,
   output fctl_pkg::fctl_trim_t                     TRIM_VALUES,
   output logic                                     LOAD_DONE
);
   import fctl_pkg::*;

   fctl_fuse_t        fuse_store;
   logic              fuse_done;
   logic              fuse_clk_w;
   logic              fuse_rd_en_w;
   logic              fuse_clk_ff;
   logic              fuse_rd_en_ff;
   logic              done_q_ff;
   logic              copy_pulse;
   logic              load_done_ff;
   logic [CAL_W-1:0]  cal_ff;
   fctl_trim_t        trim_ff;
   logic              sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
   logic              sen_s1_ff, sen_s2_ff;
   logic              sdi_s1_ff, sdi_s2_ff;
   logic              sclk_rise;
   logic              sclk_fall;
   fctl_ser_t         ser_ff;
   logic [HDR_BITS-1:0] hdr_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic [CAL_W-1:0]  shift_ff;
   logic              mode_ok;
   logic              is_read;
   logic              is_trim;
   logic [CNT_W-1:0]  data_len;
   logic              commit_cal;
   logic              commit_trim;
   logic              sdat_o_ff;
   logic              sdat_oe_ff;
   fctl_cfg_t         cfg_sel;
   logic [CONST_W-1:0] cal_const_ff;
   logic              shunt_ff;
   logic signed [PROD_W-1:0] prod;
   logic signed [PROD_W-1:0] scaled;
   logic              corr_valid_ff;
   logic signed [RES_W-1:0] corr_ff;
   logic              corr_ovf_ff;

   // fuse store reader; it owns the slow cell clock
   fctl_fuse_reader u_reader (
      .clk        (CLOCK),
      .rst_b      (RST_B),
      .fuse_bit   (FUSE_BIT),
      .fuse_store (fuse_store),
      .fuse_clk   (fuse_clk_w),
      .fuse_rd_en (fuse_rd_en_w),
      .done       (fuse_done)
   );

   // re-register reader outputs so every top output leaves a flop here
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         fuse_clk_ff   <= 1'b0;
         fuse_rd_en_ff <= 1'b0;
      end else begin
         fuse_clk_ff   <= fuse_clk_w;
         fuse_rd_en_ff <= fuse_rd_en_w;
      end
   end

   // one copy pulse when the whole store has been read
   assign copy_pulse = fuse_done & ~done_q_ff;

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         done_q_ff    <= 1'b0;
         load_done_ff <= 1'b0;
      end else begin
         done_q_ff <= fuse_done;
         if (copy_pulse) begin
            load_done_ff <= 1'b1;
         end
      end
   end

   // serial pins cross two flops; the third sclk flop only feeds edge detection
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_s1_ff <= 1'b0;
         sclk_s2_ff <= 1'b0;
         sclk_s3_ff <= 1'b0;
         sen_s1_ff  <= 1'b0;
         sen_s2_ff  <= 1'b0;
         sdi_s1_ff  <= 1'b0;
         sdi_s2_ff  <= 1'b0;
      end else begin
         sclk_s1_ff <= SCLK;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_s3_ff <= sclk_s2_ff;
         sen_s1_ff  <= SEN;
         sen_s2_ff  <= sen_s1_ff;
         sdi_s1_ff  <= SDAT_I;
         sdi_s2_ff  <= sdi_s1_ff;
      end
   end

   assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
   assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;

   // header decode: mode nibble, read bit, register select
   assign mode_ok  = (hdr_ff[HDR_MODE_LSB +: 4] == MODE_REG_ACCESS);
   assign is_read  = hdr_ff[HDR_RW_BIT];
   assign is_trim  = hdr_ff[HDR_SEL_BIT];
   assign data_len = is_trim ? CNT_W'(TRIM_W) : CNT_W'(CAL_W);

   // a write commits only when the frame ends with exactly the register's length
   assign commit_cal  = (ser_ff == SER_DATA) && !sen_s2_ff && mode_ok && !is_read
                        && !is_trim && cnt_ff == data_len;
   assign commit_trim = (ser_ff == SER_DATA) && !sen_s2_ff && mode_ok && !is_read
                        && is_trim && cnt_ff == data_len;

   // frame state: enable high frames a transfer, enable low aborts it at any point
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         ser_ff <= SER_IDLE;
         hdr_ff <= '0;
         cnt_ff <= '0;
      end else if (!sen_s2_ff) begin
         ser_ff <= SER_IDLE;
         cnt_ff <= '0;
      end else begin
         unique case (ser_ff)
            SER_IDLE: begin
               ser_ff <= SER_HDR;
               cnt_ff <= '0;
            end
            SER_HDR: begin
               if (sclk_rise) begin
                  hdr_ff <= {hdr_ff[HDR_BITS-2:0], sdi_s2_ff};
                  if (cnt_ff == CNT_W'(HDR_BITS - 1)) begin
                     ser_ff <= SER_DATA;
                     cnt_ff <= '0;
                  end else begin
                     cnt_ff <= cnt_ff + 8'h01;
                  end
               end
            end
            SER_DATA: begin
               if (sclk_rise && cnt_ff != 8'hFF) begin
                  cnt_ff <= cnt_ff + 8'h01;   // count saturates at 8'hFF, so overlong frames never commit
               end
            end
         endcase
      end
   end

   // shared shift register: writes shift in on rising sclk, reads shift out on falling
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         shift_ff   <= '0;
         sdat_o_ff  <= 1'b0;
         sdat_oe_ff <= 1'b0;
      end else if (!sen_s2_ff) begin
         sdat_oe_ff <= 1'b0;
      end else if (ser_ff == SER_HDR && sclk_rise && cnt_ff == CNT_W'(HDR_BITS - 1)) begin
         // last header bit is hdr_ff[0] after this edge, so decode from the incoming bits
         if (hdr_ff[HDR_MODE_LSB-1 +: 4] == MODE_REG_ACCESS && hdr_ff[HDR_RW_BIT-1]) begin
            if (sdi_s2_ff) begin
               shift_ff  <= {trim_ff, {(CAL_W - TRIM_W){1'b0}}} << 1;
               sdat_o_ff <= trim_ff[TRIM_W-1];
            end else begin
               shift_ff  <= cal_ff << 1;
               sdat_o_ff <= cal_ff[CAL_W-1];
            end
            sdat_oe_ff <= 1'b1;
         end else begin
            shift_ff   <= '0;
            sdat_oe_ff <= 1'b0;
         end
      end else if (ser_ff == SER_DATA) begin
         if (is_read && sclk_fall) begin
            sdat_o_ff <= shift_ff[CAL_W-1];
            shift_ff  <= shift_ff << 1;
         end else if (!is_read && sclk_rise) begin
            shift_ff <= {shift_ff[CAL_W-2:0], sdi_s2_ff};
         end
      end
   end

   // calibration register: serial write wins over the fuse copy in the same cycle
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         cal_ff <= {(NUM_GAIN + NUM_VOLT){CONST_DEFAULT}};
      end else if (commit_cal) begin
         cal_ff <= shift_ff;
      end else if (copy_pulse) begin
         cal_ff <= fuse_store.fuse_calibration_field;
      end
   end

   // trim register, same precedence
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         trim_ff <= '0;
      end else if (commit_trim) begin
         trim_ff <= fctl_trim_t'(shift_ff[TRIM_W-1:0]);
      end else if (copy_pulse) begin
         trim_ff <= fuse_store.fuse_trim_field;
      end
   end

   // channel in use picks the select bits; spare fuse bits are deliberately left unread
   assign cfg_sel = CHAN_B_ACTIVE ? CHAN_B_CFG : CHAN_A_CFG;

   // constant selection and the current-sense switch, registered for clean outputs
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         cal_const_ff <= CONST_DEFAULT;
         shunt_ff     <= 1'b0;
      end else begin
         cal_const_ff <= fctl_pick(cal_ff, cfg_sel);
         shunt_ff     <= cfg_sel.shunt_path_select;
      end
   end

   // correction: raw times constant, scaled back down, clipped to +/-32767
   assign prod   = RAW_RESULT * $signed({1'b0, cal_const_ff});
   assign scaled = prod >>> CAL_SHIFT;

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         corr_valid_ff <= 1'b0;
         corr_ff       <= '0;
         corr_ovf_ff   <= 1'b0;
      end else begin
         // results before the copy would use unloaded constants, so they are dropped
         corr_valid_ff <= RAW_VALID && load_done_ff;
         if (RAW_VALID && load_done_ff) begin
            if (scaled > PROD_W'(RES_MAX)) begin
               corr_ff     <= RES_MAX;
               corr_ovf_ff <= 1'b1;
            end else if (scaled < PROD_W'(RES_MIN)) begin
               corr_ff     <= RES_MIN;
               corr_ovf_ff <= 1'b1;
            end else begin
               corr_ff     <= scaled[RES_W-1:0];
               corr_ovf_ff <= 1'b0;
            end
         end
      end
   end

   assign FUSE_CLK           = fuse_clk_ff;
   assign FUSE_RD_EN         = fuse_rd_en_ff;
   assign SDAT_O             = sdat_o_ff;
   assign SDAT_OE            = sdat_oe_ff;
   assign CORR_VALID         = corr_valid_ff;
   assign CORR_RESULT        = corr_ff;
   assign CORR_OVF           = corr_ovf_ff;
   assign CAL_CONST          = cal_const_ff;
   assign SHUNT_SWITCH_CLOSE = shunt_ff;
   assign TRIM_VALUES        = trim_ff;
   assign LOAD_DONE          = load_done_ff;

   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   sequence s_copy_alone;
      copy_pulse && !commit_cal && !commit_trim;
   endsequence

   property p_copy_cal;
      s_copy_alone |=> cal_ff == $past(fuse_store.fuse_calibration_field);
   endproperty
   a_copy_cal: assert property (p_copy_cal) else $error("cal copy missed");

   property p_copy_trim;
      s_copy_alone |=> trim_ff == $past(fuse_store.fuse_trim_field);
   endproperty
   a_copy_trim: assert property (p_copy_trim) else $error("trim copy missed");

   property p_write_cal;
      commit_cal |=> cal_ff == $past(shift_ff) ##1 !commit_cal;
   endproperty
   a_write_cal: assert property (p_write_cal) else $error("cal write lost");

   property p_write_trim;
      commit_trim |=> trim_ff == fctl_trim_t'($past(shift_ff[TRIM_W-1:0]));
   endproperty
   a_write_trim: assert property (p_write_trim) else $error("trim write lost");

   property p_pick_gain;
      cfg_sel.shunt_path_select |=> CAL_CONST == fctl_slice($past(cal_ff),
         int'({$past(cfg_sel.gain_select_high), $past(cfg_sel.gain_select_low)}));
   endproperty
   a_pick_gain: assert property (p_pick_gain) else $error("gain constant wrong");

   property p_pick_fixed;
      !cfg_sel.shunt_path_select && cfg_sel.voltage_cal_select[2:1] == 2'b11
         |=> CAL_CONST == CONST_DEFAULT;
   endproperty
   a_pick_fixed: assert property (p_pick_fixed) else $error("fixed constant wrong");

   property p_switch;
      1'b1 |=> SHUNT_SWITCH_CLOSE == $past(cfg_sel.shunt_path_select);
   endproperty
   a_switch: assert property (p_switch) else $error("shunt switch mismatch");

   property p_no_early_result;
      !load_done_ff |=> !CORR_VALID;
   endproperty
   a_no_early_result: assert property (p_no_early_result) else $error("result before load");

   property p_result_follows;
      RAW_VALID && load_done_ff && $stable(cal_const_ff) |=> CORR_VALID && !CORR_OVF
         |-> CORR_RESULT == $past(scaled[RES_W-1:0]);
   endproperty
   a_result_follows: assert property (p_result_follows) else $error("correction wrong");

endmodule // fctl_top

/* File: bench/fctl_mcu_model.sv */
// fctl_mcu_model: microcontroller side of the three-wire configuration port.
// assumes: the bench calls frame() from its main sequence; clk is the system clock.
`timescale 1ns/1ns
module fctl_mcu_model (
   input  wire logic clk,
   output logic      sclk,
   output logic      sen,
   output logic      sdat,
   input  wire logic sdat_o
);
   initial begin
      sclk = 1'b0;
      sen  = 1'b0;
      sdat = 1'b0;
   end
   // one frame: header, then n data bits taken from the top of d; reads land in q
   task automatic frame(input logic [5:0] hdr, input logic [109:0] d, input int n,
                        output logic [109:0] q);
      logic [115:0] s;
      s = {hdr, d};  // mode field first, then rw and select
      q = '0;
      sen = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 6 + n; i++) begin
         sdat = s[115-i];  // msb first
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         // device moves its bit on each falling sclk, the first right after header rise 6
         if (i >= 5 && i < 5 + n) q = {q[108:0], sdat_o};
         sclk = 1'b0;
      end
      // line left floating after the frame: show the inverse, not a stale value
      sdat = ~sdat;
      sen = 1'b0;
      repeat (8) @(negedge clk);
   endtask
endmodule // fctl_mcu_model

/* File: bench/tb_top.sv */
// tb_top: fuse image, selection sweep, serial access and correction checks.
// assumes: fctl_pkg compiled first; the fuse cells are modelled here.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   import fctl_pkg::*;
   logic clk = 0, rst_b = 0, fbit = 0, raw_v = 0, chb = 0;
   logic sclk, sen, serial_config_port;
   fctl_cfg_t cfg_a = '0, cfg_b = '0;
   logic signed [15:0] raw = 0;
   wire fclk, frd, sdo, soe, cv, ovf, shc, ld;
   wire signed [15:0] cres;
   wire [10:0] cc;
   fctl_trim_t tv;
   int n_fail = 0, total_checks = 0, idx = 187;
   logic [187:0] img;
   logic [109:0] cal, q;
   logic [19:0] tr;
   logic [10:0] ec;
   realtime tl = 0;
   logic oe_seen = 0;
   fctl_top fctl_top_i (.CLOCK(clk), .RST_B(rst_b), .FUSE_CLK(fclk), .FUSE_RD_EN(frd),
      .FUSE_BIT(fbit), .SCLK(sclk), .SEN(sen), .SDAT_I(serial_config_port), .SDAT_O(sdo), .SDAT_OE(soe),
      .CHAN_A_CFG(cfg_a), .CHAN_B_CFG(cfg_b), .CHAN_B_ACTIVE(chb), .RAW_VALID(raw_v),
      .RAW_RESULT(raw), .CORR_VALID(cv), .CORR_RESULT(cres), .CORR_OVF(ovf),
      .CAL_CONST(cc), .SHUNT_SWITCH_CLOSE(shc), .TRIM_VALUES(tv), .LOAD_DONE(ld));
   fctl_mcu_model fctl_mcu_model_i (.clk(clk), .sclk(sclk), .sen(sen), .sdat(serial_config_port),
      .sdat_o(sdo));
   initial forever #10 clk = ~clk;
   // fuse cells: next bit after each rising cell clock, bit 187 first
   always @(posedge fclk) if (idx >= 0) begin
      @(negedge clk);
      fbit = img[idx];
      idx--;
   end
   // remembers whether the device drove the data line since it was last cleared
   always @(negedge clk) if (soe === 1'b1) oe_seen = 1'b1;
   // cell clock edges at least one microsecond apart while reading
   always @(fclk) if (frd === 1'b1) begin
      `CHK($realtime - tl >= 999.0, 1'b1)
      tl = $realtime;
   end
   // bench copy of the mux; written apart from the package helper on purpose
   function automatic logic [10:0] exp_c(fctl_cfg_t c);
      int i;
      i = c.shunt_path_select ? int'({c.gain_select_high, c.gain_select_low})
                              : 4 + int'(c.voltage_cal_select);
      if (!c.shunt_path_select && c.voltage_cal_select > 3'h5) return 11'h60C;
      return 11'(cal >> (11 * (9 - i)));
   endfunction
   task automatic sel_sweep;
      fctl_cfg_t c;
      for (int k = 0; k < 24; k++) begin
         c = 17'($urandom);
         c.shunt_path_select = (k < 16);
         {c.gain_select_high, c.gain_select_low} = 2'(k);
         if (k >= 16) c.voltage_cal_select = 3'(k);
         chb = k[2];
         cfg_a = chb ? ~c : c;
         cfg_b = chb ? c : ~c;
         ec = exp_c(c);
         repeat (3) @(negedge clk);
         `CHK(cc, ec)
         `CHK(shc, c.shunt_path_select)
      end
   endtask
   task automatic measure(int n);
      logic signed [31:0] p;
      for (int i = 0; i < n; i++) begin
         raw = (i == 0) ? 16'sh7FFF : (i == 1) ? 16'sh8000 : 16'($urandom);
         p = (raw * $signed({1'b0, ec})) >>> 10;
         raw_v = 1'b1;
         @(negedge clk);
         raw_v = 1'b0;
         for (int j = 0; j < 3 && cv !== 1'b1; j++) @(negedge clk);
         `CHK(cv, 1'b1)
         `CHK(cres, p > 32767 ? 16'sh7FFF : p < -32767 ? 16'sh8001 : 16'(p))
         `CHK(ovf, p > 32767 || p < -32767)
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // hang guard: the whole run fits well inside this bound
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      void'($urandom(24419));
      for (int i = 0; i < 188; i++) img[i] = 1'($urandom);
      repeat (8) @(negedge clk);
      `CHK(cc, 11'h60C)
      `CHK(tv, 20'h0)
      rst_b = 1'b1;
      raw_v = 1'b1;
      @(negedge clk);
      raw_v = 1'b0;
      `CHK(cv, 1'b0)
      for (int i = 0; i < 20000 && ld !== 1'b1; i++) @(negedge clk);
      `CHK(ld, 1'b1)
      if (ld !== 1'b1) end_of_test();
      `CHK(frd, 1'b0)
      `CHK(tv, img[182:163])
      cal = img[162:53];
      sel_sweep();
      measure(16);
      $display("test fuse copy and selection done");
      tr = 20'($urandom);
      fctl_mcu_model_i.frame(6'h21, {tr, 90'h0}, 20, q);
      `CHK(tv, tr)
      `CHK(oe_seen, 1'b0)
      fctl_mcu_model_i.frame(6'h23, '0, 20, q);
      `CHK(q[19:0], tr)
      `CHK(oe_seen, 1'b1)
      `CHK(soe, 1'b0)
      oe_seen = 1'b0;
      fctl_mcu_model_i.frame(6'h1D, {~tr, 90'h0}, 20, q);
      `CHK(tv, tr)
      `CHK(oe_seen, 1'b0)
      fctl_mcu_model_i.frame(6'h21, {~tr, 90'h0}, 19, q);
      `CHK(tv, tr)
      $display("test trim access done");
      for (int i = 0; i < 110; i++) cal[i] = 1'($urandom);
      fctl_mcu_model_i.frame(6'h20, cal, 110, q);
      sel_sweep();
      fctl_mcu_model_i.frame(6'h22, '0, 110, q);
      `CHK(q, cal)
      measure(32);
      $display("test calibration access done");
      end_of_test();
   end
endmodule // tb_top
